// ### design/aof_pkg.sv
// Constants shared by the converter output formatter.
// Assumes a single 125 MHz system clock and an AXI4-Lite register bus.
package aof_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned MCLK_MHZ = 125;
  localparam int unsigned SLEEP_WAKE_US = 2000;
  localparam int unsigned SLEEP_WAKE_CYCLES = SLEEP_WAKE_US * MCLK_MHZ;
  localparam int unsigned NAP_WAKE_SAMPLES = 100;
  localparam int unsigned WAKE_CNT_W = 20;
  localparam int unsigned PERIOD_W = 8;
  localparam int unsigned HIST_LEN = 64;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] TIMING_OFF = 8'h00;
  localparam logic [7:0] OUTMODE_OFF = 8'h04;
  localparam logic [7:0] FORMAT_OFF = 8'h08;
  localparam logic [7:0] POWER_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  // ==========================================================
  // Field positions
  localparam int TIM_DCS = 0;
  localparam int TIM_PHASE = 1;
  localparam int TIM_INV = 3;
  localparam int OM_MODE = 0;
  localparam int OM_OFF = 2;
  localparam int OM_TERM = 3;
  localparam int OM_ILVDS = 4;
  localparam int FMT_TWOS = 0;
  localparam int FMT_RAND = 1;
  localparam int FMT_ABP = 2;
  localparam int FMT_TEST_EN = 3;
  localparam int FMT_TEST_SEL = 4;
  localparam int ST_VALID = 0;
  localparam int ST_PERIOD = 8;
  localparam int ST_CURRENT = 16;

  // ==========================================================
  // Reset values
  localparam logic [3:0] TIMING_RST = 4'h0;
  localparam logic [6:0] OUTMODE_RST = 7'h00;
  localparam logic [5:0] FORMAT_RST = 6'h00;
  localparam logic [1:0] POWER_RST = 2'h0;

  // ==========================================================
  // Encodings
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_DDR_LVDS = 2'h1;
  localparam logic [1:0] MODE_DDR_CMOS = 2'h2;
  localparam logic [1:0] PWR_NAP = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h3;
  localparam logic [1:0] TEST_ONES = 2'h0;
  localparam logic [1:0] TEST_ZEROS = 2'h1;
  localparam logic [1:0] TEST_ALT = 2'h2;
  localparam logic [1:0] TEST_CHECK = 2'h3;
  localparam logic [12:0] CHECKER_PAT = 13'h1555;
  localparam logic [11:0] ODD_BITS = 12'haaa;
  localparam logic [11:0] MID_MSB = 12'h800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Driver current in units of 10 uA, indexed by the 3-bit code
  localparam logic [9:0] CUR_000 = 10'h15e;
  localparam logic [9:0] CUR_001 = 10'h190;
  localparam logic [9:0] CUR_010 = 10'h1c2;
  localparam logic [9:0] CUR_011 = 10'h000;
  localparam logic [9:0] CUR_100 = 10'h12c;
  localparam logic [9:0] CUR_101 = 10'h0fa;
  localparam logic [9:0] CUR_110 = 10'h0d2;
  localparam logic [9:0] CUR_111 = 10'h0af;
  localparam logic [3:0] TERM_MUL = 4'h8;
  localparam logic [13:0] TERM_DIV = 14'h0005;

  typedef enum logic [4:0] {
    PS_RUN = 5'b00001,
    PS_SLEEP = 5'b00010,
    PS_NAP = 5'b00100,
    PS_WAKE_SLEEP = 5'b01000,
    PS_WAKE_NAP = 5'b10000
  } aof_pwr_t;

endpackage

// ### design/aof_formatter.sv
// Output formatting stage of a 12-bit sampling converter.
// Assumes the core word and flags change only near the encode falling
// edge, so they are steady when the encode rising edge is found.
// Functional notes
// - LVDS current default 3.5 mA, seven choices
// - Termination on scales current by 1.6
// - Overrange flag high on over or underrange
// - Flag shares the data pipeline delay
// - Full rate: data changes on clock falling
// - DDR: data changes on both clock edges
// - Output clock delayed 0/45/90/135 degrees
// - Separate invert bit for output clock
// - Offset binary at reset, twos optional
// - Twos complement is MSB inverted
// - Out of range saturates to end codes
// - Randomizer XORs upper bits with LSB
// - Polarity and randomizer independent; forces binary
// - Four test patterns on flag and data
// - Test pattern overrides all formatting
// - Output disable floats every output
// - Sleep by register or pin, 2 ms wake
// - Nap by register, 100 sample wake
// - DDR pairs two bits per line
// - Current code table, 011 unused
`timescale 1ns/1ns
`default_nettype none

module aof_formatter
  import aof_pkg::*;
#(
  parameter int unsigned SLEEP_WAKE_CYC = SLEEP_WAKE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Converter core and pins, all asynchronous to mclk
  input wire logic encode_clk,
  input wire logic [11:0] core_word,
  input wire logic core_over,
  input wire logic core_under,
  input wire logic sleep_pin,
  input wire logic programming_port_select,
  // Output pins
  output logic [11:0] sample_word_bits,
  output logic overrange_flag,
  output logic forwarded_output_clock_p,
  output logic forwarded_output_clock_n,
  output logic output_enable,
  // Driver and power controls
  output logic [9:0] lvds_current_10ua,
  output logic lvds_term_en,
  output logic lvds_mode,
  output logic stabilizer_en,
  output logic core_powered_down,
  output logic output_valid
);

  // ==========================================================
  // Input synchronisers
  logic [16:0] in_raw;
  logic [16:0] in_s1_reg;
  logic [16:0] in_s2_reg;
  assign in_raw = {programming_port_select, sleep_pin, encode_clk,
                   core_over, core_under, core_word};

  // Two stages before anything looks at the pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_s1_reg <= 17'h00000;
      in_s2_reg <= 17'h00000;
    end else begin
      in_s1_reg <= in_raw;
      in_s2_reg <= in_s1_reg;
    end
  end

  wire logic par_mode = in_s2_reg[16];
  wire logic sleep_pin_s = in_s2_reg[15];
  wire logic enc_s = in_s2_reg[14];
  wire logic over_s = in_s2_reg[13];
  wire logic under_s = in_s2_reg[12];
  wire logic [11:0] word_s = in_s2_reg[11:0];

  // ==========================================================
  // Registers and bus slave
  logic [3:0] timing_reg;
  logic [6:0] outmode_reg;
  logic [5:0] format_reg;
  logic [1:0] power_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // Address and data are taken in either order; response after both
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic wsel_tim = (awaddr_reg == TIMING_OFF);
  wire logic wsel_om = (awaddr_reg == OUTMODE_OFF);
  wire logic wsel_fmt = (awaddr_reg == FORMAT_OFF);
  wire logic wsel_pwr = (awaddr_reg == POWER_OFF);
  wire logic wr_en = wr_fire && wstrb0_reg;
  assign wr_hit = wsel_tim || wsel_om || wsel_fmt || wsel_pwr;
  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready = !w_got_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Read decode; the status word is read-only and unmapped reads give 0
  assign rd_hit = (s_axi_araddr == TIMING_OFF) ||
                  (s_axi_araddr == OUTMODE_OFF) ||
                  (s_axi_araddr == FORMAT_OFF) ||
                  (s_axi_araddr == POWER_OFF) ||
                  (s_axi_araddr == STATUS_OFF);
  assign rd_word = (s_axi_araddr == TIMING_OFF) ? {28'h0, timing_reg} :
                   (s_axi_araddr == OUTMODE_OFF) ? {25'h0, outmode_reg} :
                   (s_axi_araddr == FORMAT_OFF) ? {26'h0, format_reg} :
                   (s_axi_araddr == POWER_OFF) ? {30'h0, power_reg} :
                   (s_axi_araddr == STATUS_OFF) ? status_word : 32'h0;

  // Write channel holding registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end

  // Control registers; all fields live in byte lane 0
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timing_reg <= TIMING_RST;
      outmode_reg <= OUTMODE_RST;
      format_reg <= FORMAT_RST;
      power_reg <= POWER_RST;
    end else if (wr_en) begin
      if (wsel_tim) timing_reg <= wdata_reg[3:0];
      if (wsel_om) outmode_reg <= wdata_reg[6:0];
      if (wsel_fmt) format_reg <= wdata_reg[5:0];
      if (wsel_pwr) power_reg <= wdata_reg[1:0];
    end
  end

  // Read channel
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Field decode
  wire logic [1:0] phase_sel = timing_reg[TIM_PHASE +: 2];
  wire logic clk_inv = timing_reg[TIM_INV];
  wire logic [1:0] out_mode = outmode_reg[OM_MODE +: 2];
  wire logic out_off = outmode_reg[OM_OFF];
  wire logic term_on = outmode_reg[OM_TERM];
  wire logic [2:0] ilvds = outmode_reg[OM_ILVDS +: 3];
  wire logic fmt_twos = format_reg[FMT_TWOS];
  wire logic fmt_rand = format_reg[FMT_RAND];
  wire logic fmt_abp = format_reg[FMT_ABP];
  wire logic test_en = format_reg[FMT_TEST_EN];
  wire logic [1:0] test_sel = format_reg[FMT_TEST_SEL +: 2];
  wire logic ddr = (out_mode == MODE_DDR_LVDS) ||
                   (out_mode == MODE_DDR_CMOS);

  // Drive current table and termination boost
  logic [9:0] cur_base;
  logic [13:0] cur_boost;
  assign cur_base = (ilvds == 3'h0) ? CUR_000 :
                    (ilvds == 3'h1) ? CUR_001 :
                    (ilvds == 3'h2) ? CUR_010 :
                    (ilvds == 3'h3) ? CUR_011 :
                    (ilvds == 3'h4) ? CUR_100 :
                    (ilvds == 3'h5) ? CUR_101 :
                    (ilvds == 3'h6) ? CUR_110 : CUR_111;
  // All table entries divide by five exactly, so x1.6 is exact
  assign cur_boost = (cur_base * TERM_MUL) / TERM_DIV;
  assign lvds_current_10ua = term_on ? cur_boost[9:0] : cur_base;
  assign lvds_term_en = term_on;
  assign lvds_mode = (out_mode == MODE_DDR_LVDS);
  // Phase shift needs the stabilizer; software must set both
  assign stabilizer_en = timing_reg[TIM_DCS];

  // ==========================================================
  // Power states
  aof_pwr_t pwr_reg;
  aof_pwr_t pwr_next;
  logic [WAKE_CNT_W-1:0] wake_cnt_reg;
  logic [WAKE_CNT_W-1:0] wake_cnt_next;
  logic enc_rise;
  // Parallel mode takes sleep from the pin; nap only by register
  wire logic sleep_req = par_mode ? sleep_pin_s :
                         (power_reg == PWR_SLEEP);
  wire logic nap_req = !par_mode && (power_reg == PWR_NAP);
  wire logic sleep_done =
    (wake_cnt_reg == WAKE_CNT_W'(SLEEP_WAKE_CYC - 1));
  wire logic nap_done =
    enc_rise && (wake_cnt_reg == WAKE_CNT_W'(NAP_WAKE_SAMPLES - 1));

  // Next power state; sleep always wins over nap
  always_comb begin
    pwr_next = pwr_reg;
    wake_cnt_next = wake_cnt_reg;
    case (pwr_reg)
      PS_RUN: begin
        if (sleep_req) pwr_next = PS_SLEEP;
        else if (nap_req) pwr_next = PS_NAP;
      end
      PS_SLEEP: begin
        wake_cnt_next = '0;
        if (!sleep_req) pwr_next = PS_WAKE_SLEEP;
      end
      PS_NAP: begin
        wake_cnt_next = '0;
        if (sleep_req) pwr_next = PS_SLEEP;
        else if (!nap_req) pwr_next = PS_WAKE_NAP;
      end
      PS_WAKE_SLEEP: begin
        wake_cnt_next = wake_cnt_reg + 1'b1;
        if (sleep_req) pwr_next = PS_SLEEP;
        else if (sleep_done) pwr_next = PS_RUN;
      end
      PS_WAKE_NAP: begin
        if (enc_rise) wake_cnt_next = wake_cnt_reg + 1'b1;
        if (sleep_req) pwr_next = PS_SLEEP;
        else if (nap_req) pwr_next = PS_NAP;
        else if (nap_done) pwr_next = PS_RUN;
      end
      default: pwr_next = PS_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwr_reg <= PS_RUN;
      wake_cnt_reg <= '0;
    end else begin
      pwr_reg <= pwr_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  wire logic running = (pwr_reg == PS_RUN);
  assign output_valid = running;
  assign core_powered_down = (pwr_reg == PS_SLEEP) || (pwr_reg == PS_NAP);

  // ==========================================================
  // Encode edges and period
  logic ref_reg;
  logic [PERIOD_W-1:0] per_cnt_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [HIST_LEN-1:0] hist_reg;
  logic [9:0] tap_prod;
  logic [5:0] tap;
  logic clk_tap;
  assign enc_rise = enc_s && !ref_reg;
  wire logic enc_fall = !enc_s && ref_reg;

  // Period in mclk cycles sets the size of an eighth-period step
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref_reg <= 1'b0;
      per_cnt_reg <= '0;
      period_reg <= '0;
      hist_reg <= '0;
    end else begin
      ref_reg <= enc_s;
      hist_reg <= {hist_reg[HIST_LEN-2:0], enc_s};
      if (enc_rise) begin
        period_reg <= per_cnt_reg;
        per_cnt_reg <= PERIOD_W'(1);
      end else if (per_cnt_reg != '1) begin
        per_cnt_reg <= per_cnt_reg + 1'b1;
      end
    end
  end

  // Delay tap, truncated to whole mclk cycles
  assign tap_prod = period_reg * phase_sel;
  assign tap = (tap_prod[9:3] > 7'd63) ? 6'h3f : tap_prod[8:3];
  assign clk_tap = (tap == 6'h00) ? enc_s : hist_reg[tap - 6'h01];

  // ==========================================================
  // Formatting path
  logic [11:0] sat_word;
  logic flag_in;
  logic [11:0] twos_word;
  logic [11:0] rand_word;
  logic [11:0] abp_word;
  logic [12:0] pat_word;
  logic [12:0] fmt_word;
  logic alt_reg;

  assign flag_in = over_s || under_s;
  assign sat_word = over_s ? 12'hfff :
                    under_s ? 12'h000 : word_s;
  // Polarity mode ignores the twos bit
  assign twos_word = (fmt_twos && !fmt_abp) ?
                     sat_word ^ MID_MSB : sat_word;
  assign rand_word = fmt_rand ?
    {rand_word_hi(twos_word), twos_word[0]} : twos_word;
  assign abp_word = fmt_abp ? rand_word ^ ODD_BITS :
                    rand_word;
  assign pat_word = (test_sel == TEST_ONES) ? 13'h1fff :
                    (test_sel == TEST_ZEROS) ? 13'h0000 :
                    (test_sel == TEST_ALT) ? {13{~alt_reg}} :
                    (alt_reg ? ~CHECKER_PAT : CHECKER_PAT);
  // Pattern goes in after formatting, so only the not-running zero overrides it
  assign fmt_word = !running ? 13'h0000 :
                    test_en ? pat_word :
                    {flag_in, abp_word};

  function automatic logic [10:0] rand_word_hi(input logic [11:0] w);
    rand_word_hi = w[11:1] ^ {11{w[0]}};
  endfunction

  // ==========================================================
  // Output registers
  logic [12:0] cap_reg;
  logic [11:0] word_out_reg;
  logic flag_out_reg;
  logic clk_p_reg;
  logic clk_n_reg;
  logic [5:0] even_bits;
  logic [5:0] odd_bits;
  assign even_bits = {fmt_word[10], fmt_word[8], fmt_word[6],
                      fmt_word[4], fmt_word[2], fmt_word[0]};
  assign odd_bits = {cap_reg[11], cap_reg[9], cap_reg[7],
                     cap_reg[5], cap_reg[3], cap_reg[1]};

  // Flag moves with the data on the falling edge in full rate and with the even half in DDR
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cap_reg <= '0;
      alt_reg <= 1'b0;
      word_out_reg <= '0;
      flag_out_reg <= 1'b0;
      clk_p_reg <= 1'b0;
      clk_n_reg <= 1'b1;
    end else begin
      clk_p_reg <= clk_tap ^ clk_inv;
      clk_n_reg <= ~(clk_tap ^ clk_inv);
      if (enc_rise) begin
        cap_reg <= fmt_word;
        alt_reg <= ~alt_reg;
        if (ddr) begin
          // Even half leaves with the rising edge
          word_out_reg <= {6'h00, even_bits};
          flag_out_reg <= fmt_word[12];
        end
      end else if (enc_fall) begin
        if (ddr) begin
          word_out_reg <= {6'h00, odd_bits};
        end else begin
          word_out_reg <= cap_reg[11:0];
          flag_out_reg <= cap_reg[12];
        end
      end
    end
  end

  assign sample_word_bits = word_out_reg;
  assign overrange_flag = flag_out_reg;
  assign forwarded_output_clock_p = clk_p_reg;
  assign forwarded_output_clock_n = clk_n_reg;
  // Slow enable meant for idle periods, not bus sharing
  assign output_enable = !out_off;

  // ==========================================================
  // Status word
  assign status_word = {6'h00, lvds_current_10ua,
                        period_reg, 7'h00, running};

endmodule

`default_nettype wire

// ### verification/aof_rx_model.sv
// Receiver model that latches the formatted output word off the link.
// Assumes zero clock phase; samples a quarter encode period after edges.
`timescale 1ns/1ns
`default_nettype none
module aof_rx_model
  import aof_pkg::*;
(
  // Link pins
  input wire logic clk_p,
  input wire logic [11:0] lines,
  input wire logic flag,
  // Decode settings
  input wire logic ddr,
  input wire logic rnd,
  input wire logic abp,
  // Captured and restored words
  output logic [12:0] raw,
  output logic [11:0] dec
);
  logic [5:0] ev;
  logic [11:0] un;
  // ====
  // Capture mid-bit, clear of the edges where the data moves
  always @(posedge clk_p) begin
    #20 ev = lines[5:0];
  end
  always @(negedge clk_p) begin
    #20 raw[12] = flag;
    for (int k = 0; k < 6; k++) begin
      raw[2*k] = ddr ? ev[k] : lines[2*k];
      raw[2*k+1] = ddr ? lines[k] : lines[2*k+1];
    end
  end
  // Undo polarity first, then the randomizer with the received LSB
  assign un = abp ? raw[11:0] ^ ODD_BITS : raw[11:0];
  assign dec = rnd ? un ^ {{11{un[0]}}, 1'b0} : un;
endmodule
`default_nettype wire

// ### verification/aof_formatter_properties.sv
// Concurrent checks on the output formatter's pins.
// Assumes it is bound into aof_formatter and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module aof_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link outputs
  input wire logic [11:0] sample_word_bits,
  input wire logic overrange_flag,
  input wire logic forwarded_output_clock_p,
  input wire logic forwarded_output_clock_n,
  // Driver and power state
  input wire logic [9:0] lvds_current_10ua,
  input wire logic lvds_term_en,
  input wire logic lvds_mode,
  input wire logic core_powered_down,
  input wire logic output_valid
);
  logic [4:0] ddr_cnt;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ====
  // Time in DDR LVDS, so stale full-rate words are not judged
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ddr_cnt <= 5'h00;
    else if (!lvds_mode) ddr_cnt <= 5'h00;
    else if (ddr_cnt != 5'h1f) ddr_cnt <= ddr_cnt + 5'h01;
  end
  a_cur_base:
    assert property (!lvds_term_en |-> lvds_current_10ua inside {10'h15e,
      10'h190, 10'h1c2, 10'h000, 10'h12c, 10'h0fa, 10'h0d2, 10'h0af})
    else $error("base current off table");
  a_cur_term:
    assert property (lvds_term_en |-> lvds_current_10ua inside {10'h230,
      10'h280, 10'h2d0, 10'h000, 10'h1e0, 10'h190, 10'h150, 10'h118})
    else $error("terminated current not scaled");
  a_clk_pair:
    assert property (forwarded_output_clock_n != forwarded_output_clock_p)
    else $error("clock pair not complementary");
  a_idle_zero:
    assert property (!output_valid [*8] ##1 !output_valid [*8] ##1
      !output_valid |-> !overrange_flag && sample_word_bits == 0)
    else $error("outputs not cleared while idle");
  a_down_invalid:
    assert property (core_powered_down |-> !output_valid)
    else $error("valid while powered down");
  a_wake_wait:
    assert property ($fell(core_powered_down) |-> !output_valid [*8])
    else $error("valid too soon after wake");
  a_valid_rise:
    assert property ($rose(output_valid) |-> !$past(core_powered_down, 8))
    else $error("valid rose close to power down");
  a_ddr_upper:
    assert property (ddr_cnt == 5'h1f |-> sample_word_bits[11:6] == 6'h00)
    else $error("upper lines busy in DDR");
  c_wake: cover property ($fell(core_powered_down));
  c_term: cover property (lvds_term_en && lvds_mode);
  c_over: cover property ($rose(overrange_flag));
endmodule
bind aof_formatter aof_props u_props (.mclk(mclk), .resetn(resetn),
  .sample_word_bits(sample_word_bits), .overrange_flag(overrange_flag),
  .forwarded_output_clock_p(forwarded_output_clock_p),
  .forwarded_output_clock_n(forwarded_output_clock_n),
  .lvds_current_10ua(lvds_current_10ua), .lvds_term_en(lvds_term_en),
  .lvds_mode(lvds_mode), .core_powered_down(core_powered_down),
  .output_valid(output_valid));
`default_nettype wire

// ### verification/tb_adc_output_formatter.sv
// Self-checking bench for the converter output formatter.
// Assumes the receiver model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_adc_output_formatter;
  import aof_pkg::*;
  logic mclk = 0, resetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic enc = 0, ovr = 0, und = 0, slp = 0, pps = 0, no = 0, nu = 0;
  logic ddr = 0, rnd = 0, abp = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [11:0] cw = 12'h000, nw = 12'h000, sw, dec;
  logic awr, wrdy, bv, arr, rv, fl, cp, cn, oe, term, lm, stab, pd, ov;
  logic [1:0] br, rr;
  logic [9:0] cur;
  logic [12:0] raw, a;
  logic [13:0] cs [4] = '{14'h0800, 14'h0a5c, 14'h2123, 14'h1123};
  logic [12:0] tp [4] = '{13'h1fff, 13'h0000, 13'h1fff, CHECKER_PAT};
  int ma [8] = '{350, 400, 450, 0, 300, 250, 210, 175};
  int mismatches = 0, checks_done = 0;
  // ====
  // System clock 8 ns; encode 80 ns on a phase of its own
  initial forever #4 mclk = ~mclk;
  initial begin
    #3;
    forever #40 enc = ~enc;
  end
  // Core sample moves near the encode falling edge, clear of capture
  always @(negedge enc) {cw, ovr, und} <= {nw, no, nu};
  aof_formatter #(.SLEEP_WAKE_CYC(20)) dut (.mclk(mclk), .resetn(resetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .encode_clk(enc),
    .core_word(cw), .core_over(ovr), .core_under(und), .sleep_pin(slp),
    .programming_port_select(pps), .sample_word_bits(sw),
    .overrange_flag(fl), .forwarded_output_clock_p(cp),
    .forwarded_output_clock_n(cn), .output_enable(oe),
    .lvds_current_10ua(cur), .lvds_term_en(term), .lvds_mode(lm),
    .stabilizer_en(stab), .core_powered_down(pd), .output_valid(ov));
  aof_rx_model rx (.clk_p(cp), .lines(sw), .flag(fl), .ddr(ddr),
    .rnd(rnd), .abp(abp), .raw(raw), .dec(dec));
  // ====
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Register write; handshakes judged mid-cycle, acted on at the edge
  task automatic axw(input logic [7:0] ad, input logic [31:0] d,
      input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge mclk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= ad;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(negedge mclk);
      ha = awv & awr;
      hw = wv & wrdy;
      hb = bv;
      r = br;
      @(posedge mclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
    bry <= 1'b0;
    @(negedge mclk);
    chk("bresp", r, er);
  endtask
  task automatic axr(input logic [7:0] ad, input logic [31:0] m, e,
      input logic [1:0] er);
    logic h, hr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    arv <= 1'b1;
    ara <= ad;
    rry <= 1'b1;
    do begin
      @(negedge mclk);
      h = arv & arr;
      hr = rv;
      d = rdat;
      r = rr;
      @(posedge mclk);
      if (h) arv <= 1'b0;
    end while (!hr);
    rry <= 1'b0;
    chk("rdata", d & m, e);
    chk("rresp", r, er);
  endtask
  // Expected {flag, sent word, restored word}
  function automatic logic [24:0] fx(input logic [11:0] w,
      input logic o, u, tw, ra, ab);
    logic [11:0] c, p;
    c = o ? 12'hfff : (u ? 12'h000 : w);
    if (tw && !ab) c[11] = ~c[11];
    p = c;
    if (ra) c = c ^ {{11{c[0]}}, 1'b0};
    if (ab) c = c ^ ODD_BITS;
    return {o | u, c, p};
  endfunction
  task automatic tf(input int i, input logic [2:0] c);
    logic [24:0] e;
    {no, nu, nw} = cs[i];
    {abp, rnd} = c[2:1];
    axw(FORMAT_OFF, {29'h0, c}, RESP_OKAY);
    repeat (4) @(negedge enc);
    e = fx(nw, no, nu, c[0], c[1], c[2]);
    chk("word", raw, e[24:12]);
    chk("restored", dec, e[11:0]);
  endtask
  task automatic wake(input int lo, input bit e);
    int n;
    n = 0;
    while (ov !== 1'b1) begin
      if (e) @(posedge enc);
      else @(posedge mclk);
      n++;
    end
    chk("wake", n >= lo, 1'b1);
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    axr(FORMAT_OFF, 32'hffffffff, 32'h0, RESP_OKAY);
    axr(8'h14, 32'hffffffff, 32'h0, RESP_SLVERR);
    axw(8'h14, 32'h3f, RESP_SLVERR);
    chk("current", cur, 10'h15e);
    for (int i = 0; i < 4; i++)
      for (int c = 0; c < 8; c++) tf(i, c[2:0]);
    axr(STATUS_OFF, 32'h0000ff01, 32'h00000a01, RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      axw(FORMAT_OFF, 32'h0f | (s << 4), RESP_OKAY);
      repeat (4) @(negedge enc);
      a = raw;
      @(negedge enc);
      chk("toggle", a ^ raw, s[1] ? 13'h1fff : 13'h0);
      chk("pattern", (a === tp[s]) ? a : raw, tp[s]);
    end
    for (int m = 0; m < 16; m++) begin
      axw(OUTMODE_OFF, {25'h0, m[2:0], m[3], 3'h1}, RESP_OKAY);
      chk("current", cur, m[3] ? ma[m[2:0]] * 8 / 5 : ma[m[2:0]]);
    end
    ddr = 1'b1;
    for (int m = 1; m < 3; m++) begin
      axw(OUTMODE_OFF, m, RESP_OKAY);
      tf(2, 3'h0);
      tf(1, 3'h7);
    end
    ddr = 1'b0;
    axw(OUTMODE_OFF, 32'h4, RESP_OKAY);
    chk("enable", oe, 1'b0);
    axw(OUTMODE_OFF, 32'h0, RESP_OKAY);
    chk("enable", oe, 1'b1);
    axw(TIMING_OFF, 32'hb, RESP_OKAY);
    chk("stabilizer", stab, 1'b1);
    axw(POWER_OFF, 32'h3, RESP_OKAY);
    chk("asleep", {pd, ov}, 2'b10);
    axw(POWER_OFF, 32'h0, RESP_OKAY);
    wake(20, 1'b0);
    axw(POWER_OFF, 32'h1, RESP_OKAY);
    chk("napping", {pd, ov}, 2'b10);
    axw(POWER_OFF, 32'h0, RESP_OKAY);
    wake(100, 1'b1);
    pps <= 1'b1;
    slp <= 1'b1;
    repeat (8) @(negedge mclk);
    chk("pin sleep", {pd, ov}, 2'b10);
    @(posedge mclk);
    slp <= 1'b0;
    wake(20, 1'b0);
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial begin
    #500000;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
